//--- design/ddrbr_map.vh
// Constants for the DDR3 burst and refresh command block.
`ifndef DDRBR_MAP_VH
`define DDRBR_MAP_VH
`define DDRBR_CLK_PERIOD_NS 10
`define DDRBR_TRFC_NS 260
`define DDRBR_TRP_NS 14
`define DDRBR_TREFI_NS 7800
`define DDRBR_AL 2'h0
`define DDRBR_CL 4'h5
`define DDRBR_CWL 4'h5
`define DDRBR_MR_BL8 2'h0
`define DDRBR_MR_OTF 2'h1
`define DDRBR_MR_BC4 2'h2
`define DDRBR_BC_BIT 12
`define DDRBR_AP_BIT 10
`define DDRBR_COL_MSB 9
`define DDRBR_BEATS_BL8 4'h8
`define DDRBR_BEATS_BC4 4'h4
`define DDRBR_TCCD_BC4 4'h4
`define DDRBR_CREDIT_MAX 8
`define DDRBR_FIFO_DEPTH 8
`define DDRBR_DATA_W 16
`endif

//--- design/ddrbr_fifo.v
// Parameterised synchronous FIFO with valid and ready on both sides.
module ddrbr_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire srst,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    // Storage array; depth must be a power of two matching AW.
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_reg;
    reg [AW-1:0] rdPtr_reg;
    reg [AW:0] count_reg;
    wire doWrite;
    wire doRead;

    // Full and empty come straight from the occupancy count.
    assign inReady = (count_reg != DEPTH[AW:0]);
    assign outValid = (count_reg != {(AW + 1){1'b0}});
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;
    assign outData = mem[rdPtr_reg];

    // Pointer and count update.
    always @(posedge clk) begin
        if (srst) begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW + 1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doRead) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            if (doWrite && !doRead) begin
                count_reg <= count_reg + 1'b1;
            end else if (doRead && !doWrite) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Array write; no reset is needed on data storage.
    always @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr_reg] <= inData;
        end
    end
endmodule // ddrbr_fifo

//--- design/ddrbr_core.v
// Device-side command decode, burst length selection and refresh timing.
`include "ddrbr_map.vh"
module ddrbr_core (
    input wire clk,
    input wire srst,
    input wire csN,
    input wire rasN,
    input wire casN,
    input wire weN,
    input wire [2:0] bankAddr,
    input wire [15:0] addr,
    input wire [1:0] mrBurstMode,
    input wire [15:0] wrData,
    input wire wrDataValid,
    output wire wrDataReady,
    input wire wrStrobeFault,
    output reg [15:0] rdData,
    output reg rdDataValid,
    output reg refreshBusy,
    output reg [7:0] bankOpen,
    output reg [15:0] refreshRow,
    output reg [15:0] burstLength,
    output reg cmdError
);
    // Command codes on {RAS#, CAS#, WE#} with CS# low.
    localparam [2:0] CMD_ACT = 3'h3;
    localparam [2:0] CMD_RD = 3'h5;
    localparam [2:0] CMD_WR = 3'h4;
    localparam [2:0] CMD_PRE = 3'h2;
    localparam [2:0] CMD_REF = 3'h1;
    // One-hot states of the burst engine.
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_WAIT = 4'h2;
    localparam [3:0] ST_BURST = 4'h4;
    localparam [3:0] ST_REF = 4'h8;
    // Cycle counts derived from the nanosecond figures, rounded up.
    localparam integer TRFC_CYC =
        (`DDRBR_TRFC_NS + `DDRBR_CLK_PERIOD_NS - 1) / `DDRBR_CLK_PERIOD_NS;
    localparam [8:0] TRFC_CNT = TRFC_CYC[8:0];

    // Command, address, mode and fault pins cross into this domain through two flops.
    reg [4:0] pinMeta_reg;
    reg [4:0] pinSync_reg;
    reg [18:0] addrMeta_reg;
    reg [18:0] addrSync_reg;
    reg [1:0] modeMeta_reg;
    reg [1:0] modeSync_reg;
    reg faultMeta_reg;
    reg faultSync_reg;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [3:0] waitCnt_reg;
    reg [3:0] beatCnt_reg;
    reg [3:0] beats_reg;
    reg isWrite_reg;
    reg autoPre_reg;
    reg [2:0] burstBank_reg;
    reg [8:0] refCnt_reg;
    reg [9:0] colAddr_reg;
    // Small array of stored words standing in for the cell array.
    reg [15:0] cells [0:1023];
    wire fifoValid;
    wire [15:0] fifoData;
    wire fifoTake;
    wire [2:0] cmd;
    wire cmdLive;
    wire [2:0] bank;
    wire [15:0] a;

    // Decode a command code only when chip select is low.
    function [2:0] decode;
        input [4:0] pins;
        begin
            decode = pins[4] ? 3'h7 : pins[3:1];
        end
    endfunction

    // Burst length from mode field and A12.
    function [3:0] beatsOf;
        input [1:0] mode;
        input bcBit;
        begin
            if (mode == `DDRBR_MR_BL8) begin
                beatsOf = `DDRBR_BEATS_BL8;
            end else if (mode == `DDRBR_MR_OTF) begin
                beatsOf = bcBit ? `DDRBR_BEATS_BL8 : `DDRBR_BEATS_BC4;
            end else begin
                beatsOf = `DDRBR_BEATS_BC4;
            end
        end
    endfunction

    // Two-flop synchronisers; only the second stage is read.
    always @(posedge clk) begin
        if (srst) begin
            pinMeta_reg <= 5'h1f;
            pinSync_reg <= 5'h1f;
            addrMeta_reg <= 19'h00000;
            addrSync_reg <= 19'h00000;
            modeMeta_reg <= 2'h0;
            modeSync_reg <= 2'h0;
            faultMeta_reg <= 1'b0;
            faultSync_reg <= 1'b0;
        end else begin
            pinMeta_reg <= {csN, rasN, casN, weN, 1'b0};
            pinSync_reg <= pinMeta_reg;
            addrMeta_reg <= {bankAddr, addr};
            addrSync_reg <= addrMeta_reg;
            modeMeta_reg <= mrBurstMode;
            modeSync_reg <= modeMeta_reg;
            faultMeta_reg <= wrStrobeFault;
            faultSync_reg <= faultMeta_reg;
        end
    end

    assign cmd = decode(pinSync_reg);
    assign cmdLive = (cmd != 3'h7);
    assign bank = addrSync_reg[18:16];
    assign a = addrSync_reg[15:0];
    // Write data drains only during a write burst, so the FIFO really fills.
    assign fifoTake = state_reg[2] && isWrite_reg && fifoValid;

    // Write data buffer between the data pins and the array.
    ddrbr_fifo #(
        .WIDTH(`DDRBR_DATA_W),
        .DEPTH(`DDRBR_FIFO_DEPTH),
        .AW(3)
    ) i_ddrbr_fifo (
        .clk(clk),
        .srst(srst),
        .inValid(wrDataValid),
        .inReady(wrDataReady),
        .inData(wrData),
        .outValid(fifoValid),
        .outReady(fifoTake),
        .outData(fifoData)
    );

    // Next-state logic for the burst and refresh engine.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cmd == CMD_REF) begin
                    state_next = ST_REF;
                end else if ((cmd == CMD_RD || cmd == CMD_WR) && bankOpen[bank]) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (waitCnt_reg == 4'h0) begin
                    state_next = ST_BURST;
                end
            end
            ST_BURST: begin
                if (beatCnt_reg + 4'h1 == beats_reg) begin
                    state_next = ST_IDLE;
                end
            end
            ST_REF: begin
                if (refCnt_reg == 9'h000) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State, counters and bank bookkeeping.
    always @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            waitCnt_reg <= 4'h0;
            beatCnt_reg <= 4'h0;
            beats_reg <= `DDRBR_BEATS_BL8;
            isWrite_reg <= 1'b0;
            autoPre_reg <= 1'b0;
            burstBank_reg <= 3'h0;
            refCnt_reg <= 9'h000;
            colAddr_reg <= 10'h000;
            bankOpen <= 8'h00;
            refreshRow <= 16'h0000;
            refreshBusy <= 1'b0;
            burstLength <= 16'h0000;
            cmdError <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmdError <= 1'b0;
            // Bank open and close from activate and precharge.
            if (state_reg[0] && cmd == CMD_ACT) begin
                bankOpen[bank] <= 1'b1;
            end else if (state_reg[0] && cmd == CMD_PRE) begin
                if (a[`DDRBR_AP_BIT]) begin
                    bankOpen <= 8'h00;
                end else begin
                    bankOpen[bank] <= 1'b0;
                end
            end
            // Access to an idle bank, or any command other than NOP during refresh, is flagged.
            if (state_reg[0] && (cmd == CMD_RD || cmd == CMD_WR) && !bankOpen[bank]) begin
                cmdError <= 1'b1;
            end
            if (state_reg[3] && cmdLive) begin
                cmdError <= 1'b1;
            end
            if (state_reg[0] && (cmd == CMD_RD || cmd == CMD_WR) && bankOpen[bank]) begin
                // Column is A0..A9 only; A12 is consumed as burst control.
                colAddr_reg <= a[`DDRBR_COL_MSB:0];
                beats_reg <= beatsOf(modeSync_reg, a[`DDRBR_BC_BIT]);
                autoPre_reg <= a[`DDRBR_AP_BIT];
                isWrite_reg <= (cmd == CMD_WR);
                burstBank_reg <= bank;
                waitCnt_reg <= (cmd == CMD_WR) ? (`DDRBR_AL + `DDRBR_CWL - 4'h2)
                                               : (`DDRBR_AL + `DDRBR_CL - 4'h2);
                beatCnt_reg <= 4'h0;
            end
            if (state_reg[1] && waitCnt_reg != 4'h0) begin
                waitCnt_reg <= waitCnt_reg - 4'h1;
            end
            if (state_reg[2]) begin
                beatCnt_reg <= beatCnt_reg + 4'h1;
                if (state_next[0]) begin
                    burstLength <= {12'h000, beats_reg};
                    if (autoPre_reg) begin
                        bankOpen[burstBank_reg] <= 1'b0;
                    end
                end
            end
            // Refresh uses the internal row counter and ignores the address.
            if (state_reg[0] && cmd == CMD_REF) begin
                refCnt_reg <= TRFC_CNT - 9'h001;
                refreshBusy <= 1'b1;
                bankOpen <= 8'h00;
            end
            if (state_reg[3]) begin
                if (refCnt_reg != 9'h000) begin
                    refCnt_reg <= refCnt_reg - 9'h001;
                end else begin
                    refreshBusy <= 1'b0;
                    refreshRow <= refreshRow + 16'h0001;
                    bankOpen <= 8'h00;
                end
            end
        end
    end

    // Array access per beat; a strobe fault only spoils the addressed word.
    always @(posedge clk) begin
        if (state_reg[2] && isWrite_reg && fifoValid) begin
            cells[colAddr_reg + {6'h00, beatCnt_reg}] <=
                faultSync_reg ? ~fifoData : fifoData;
        end
    end

    // Read data and its valid flag come from flip-flops.
    always @(posedge clk) begin
        if (srst) begin
            rdData <= 16'h0000;
            rdDataValid <= 1'b0;
        end else begin
            rdDataValid <= state_reg[2] && !isWrite_reg;
            rdData <= cells[colAddr_reg + {6'h00, beatCnt_reg}];
        end
    end
endmodule // ddrbr_core

//--- dv/ddrbr_core_chk.sv
// Port-level assertions for the burst and refresh command block.
`include "ddrbr_map.vh"
module ddrbr_core_chk (
    input wire clk,
    input wire srst,
    input wire csN,
    input wire rasN,
    input wire casN,
    input wire weN,
    input wire [7:0] bankOpen,
    input wire [15:0] refreshRow,
    input wire [15:0] burstLength,
    input wire refreshBusy,
    input wire cmdError,
    input wire rdDataValid
);
    timeunit 1ns;
    timeprecision 1ps;
    // Rounded up, so a refresh time that is not a whole number of cycles still fits.
    localparam int TRFC_CYC =
        (`DDRBR_TRFC_NS + `DDRBR_CLK_PERIOD_NS - 1) / `DDRBR_CLK_PERIOD_NS;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Refresh pattern on the pins while every bank is idle.
    wire refCmd = !csN && !rasN && !casN && weN && bankOpen == 8'h00 && !refreshBusy;
    // Busy length is counted here, since a repetition cannot reach the full span.
    logic [5:0] busyCnt;
    always_ff @(posedge clk) begin
        if (srst) busyCnt <= 6'h00;
        else busyCnt <= refreshBusy ? busyCnt + 6'h01 : 6'h00;
    end
    chk_ref_start: assert property (refCmd |-> ##[1:4] refreshBusy)
        else $error("refresh did not start");
    chk_ref_span: assert property ($fell(refreshBusy) |-> busyCnt == 6'(TRFC_CYC))
        else $error("refresh busy span wrong");
    chk_ref_idle: assert property (refreshBusy |-> bankOpen == 8'h00)
        else $error("bank open during refresh");
    chk_row_source: assert property ($changed(refreshRow) |->
        (refreshBusy || $past(refreshBusy)) or ##[1:2] refreshBusy)
        else $error("row counter moved outside refresh");
    chk_burst_size: assert property ($changed(burstLength) |->
        burstLength == 16'h0004 || burstLength == 16'h0008)
        else $error("burst length not four or eight");
    chk_err_pulse: assert property (cmdError |=> !cmdError)
        else $error("error flag longer than one cycle");
    chk_beat_run: assert property ($rose(rdDataValid) |-> rdDataValid[*4])
        else $error("read burst shorter than four beats");
    chk_quiet_ref: assert property (refreshBusy |-> !rdDataValid)
        else $error("read data during refresh");
endmodule // ddrbr_core_chk

bind ddrbr_core ddrbr_core_chk i_ddrbr_core_chk (.clk(clk), .srst(srst), .csN(csN),
    .rasN(rasN), .casN(casN), .weN(weN), .bankOpen(bankOpen), .refreshRow(refreshRow),
    .burstLength(burstLength), .refreshBusy(refreshBusy), .cmdError(cmdError),
    .rdDataValid(rdDataValid));

//--- dv/ddrbr_ctrl_model.sv
// Behavioural memory controller that drives commands and write data.
`include "ddrbr_map.vh"
module ddrbr_ctrl_model (
    input wire clk,
    input wire wrDataReady,
    output logic csN,
    output logic rasN,
    output logic casN,
    output logic weN,
    output logic [2:0] bankAddr,
    output logic [15:0] addr,
    output logic [15:0] wrData,
    output logic wrDataValid
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CP = `DDRBR_CLK_PERIOD_NS;
    localparam int TRP_CYC = (`DDRBR_TRP_NS + CP - 1) / CP;
    localparam int TRFC_CYC = (`DDRBR_TRFC_NS + CP - 1) / CP;
    localparam int TREFI_CYC = `DDRBR_TREFI_NS / CP;
    localparam int CREDIT_MAX = `DDRBR_CREDIT_MAX;
    // Refreshes sent minus intervals elapsed; a negative value means refreshes are owed.
    int credit = 0;
    // Cycles into the current refresh interval.
    int tickCnt = 0;
    // Set once more refreshes are owed than may ever be postponed.
    logic creditFault = 1'b0;
    // Interval timer: each elapsed interval owes one more refresh.
    always @(posedge clk) begin
        if (tickCnt == TREFI_CYC - 1) begin
            tickCnt <= 0;
            if (credit > -CREDIT_MAX) begin
                credit <= credit - 1;
            end else begin
                creditFault <= 1'b1;
            end
        end else begin
            tickCnt <= tickCnt + 1;
        end
    end
    initial begin
        {csN, rasN, casN, weN} = 4'hf;
        bankAddr = 3'h0;
        addr = 16'h0000;
        wrData = 16'h0000;
        wrDataValid = 1'b0;
    end
    // One command for one cycle, then deselect; released bank and address pins show inverted values.
    task automatic cmd(input logic [2:0] rcw, input logic [2:0] ba, input logic [15:0] a);
        @(negedge clk);
        csN = 1'b0;
        {rasN, casN, weN} = rcw;
        bankAddr = ba;
        addr = a;
        @(negedge clk);
        csN = 1'b1;
        bankAddr = ~ba;
        addr = ~a;
    endtask
    // Push words, holding each until the queue has room.
    task automatic push(input logic [15:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            wrData = base + 16'(i);
            wrDataValid = 1'b1;
            while (!wrDataReady) @(negedge clk);
        end
        @(negedge clk);
        wrDataValid = 1'b0;
        wrData = ~wrData;
    endtask
    // Each refresh is its own command, sent after all banks sit idle.
    // The address is a don't-care on it, and only deselect follows until it is done.
    // Early refreshes beyond the cap earn nothing, so the credit stops there.
    task automatic refresh();
        cmd(3'h2, 3'h0, 16'h0400);
        repeat (TRP_CYC + 2) @(negedge clk);
        cmd(3'h1, 3'h0, 16'hffff);
        if (credit < CREDIT_MAX) credit++;
        repeat (TRFC_CYC + 6) @(negedge clk);
    endtask
    // Pay back every postponed refresh, as is needed before self-refresh entry.
    task automatic drain();
        while (credit < 0) refresh();
    endtask
endmodule // ddrbr_ctrl_model

//--- dv/tb_ddrbr_core.sv
// Self-checking bench for the burst and refresh command block.
`include "ddrbr_map.vh"
module tb_ddrbr_core;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] ACT = 3'h3, RD = 3'h5, WR = 3'h4, PRE = 3'h2;
    logic clk, srst, wrStrobeFault, csN, rasN, casN, weN, wrDataValid, wrDataReady;
    logic rdDataValid, refreshBusy, cmdError;
    logic [1:0] mrBurstMode;
    logic [2:0] bankAddr;
    logic [7:0] bankOpen;
    logic [15:0] addr, wrData, rdData, refreshRow, burstLength, nerr;
    logic [15:0] got [$];
    int n_fail = 0;
    int num_checks = 0;
    ddrbr_core i_ddrbr_core (.clk(clk), .srst(srst), .csN(csN), .rasN(rasN), .casN(casN),
        .weN(weN), .bankAddr(bankAddr), .addr(addr), .mrBurstMode(mrBurstMode),
        .wrData(wrData), .wrDataValid(wrDataValid), .wrDataReady(wrDataReady),
        .wrStrobeFault(wrStrobeFault), .rdData(rdData), .rdDataValid(rdDataValid),
        .refreshBusy(refreshBusy), .bankOpen(bankOpen), .refreshRow(refreshRow),
        .burstLength(burstLength), .cmdError(cmdError));
    ddrbr_ctrl_model i_ddrbr_ctrl_model (.clk(clk), .wrDataReady(wrDataReady), .csN(csN),
        .rasN(rasN), .casN(casN), .weN(weN), .bankAddr(bankAddr), .addr(addr),
        .wrData(wrData), .wrDataValid(wrDataValid));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Gather beats and error pulses over a span longer than any burst.
    task automatic grab();
        got = {};
        nerr = 16'h0000;
        repeat (24) begin
            @(negedge clk);
            if (rdDataValid === 1'b1) got.push_back(rdData);
            if (cmdError === 1'b1) nerr++;
        end
    endtask
    // Burst size for one mode, chop bit and precharge choice.
    task automatic t_size(input logic [1:0] mode, input logic chop, input logic ap);
        logic [15:0] n;
        n = (mode == `DDRBR_MR_BL8 || (mode == `DDRBR_MR_OTF && chop)) ? 16'h0008 : 16'h0004;
        mrBurstMode = mode;
        i_ddrbr_ctrl_model.cmd(ACT, 3'h2, 16'h0000);
        i_ddrbr_ctrl_model.cmd(RD, 3'h2, {3'h0, chop, 1'b0, ap, 10'h040});
        grab();
        chk16("beats", n, 16'(got.size()));
        chk16("burst length", n, burstLength);
        chk16("errors", 16'h0000, nerr);
        if (!ap) i_ddrbr_ctrl_model.cmd(PRE, 3'h2, 16'h0000);
        repeat (4) @(negedge clk);
        chk16("banks closed", 16'h0000, {8'h00, bankOpen});
    endtask
    // Access to a bank that was never opened is refused.
    task automatic t_closed();
        i_ddrbr_ctrl_model.cmd(RD, 3'h5, 16'h1000);
        grab();
        chk16("closed errors", 16'h0001, nerr);
        chk16("closed beats", 16'h0000, 16'(got.size()));
    endtask
    // Fill the queue until it refuses, write eight, read four back chopped.
    task automatic t_data(input logic fault);
        i_ddrbr_ctrl_model.push(16'h5a00, 8);
        chk16("queue full", 16'h0000, {15'h0000, wrDataReady});
        mrBurstMode = `DDRBR_MR_OTF;
        i_ddrbr_ctrl_model.cmd(ACT, 3'h1, 16'h0000);
        wrStrobeFault = fault;
        i_ddrbr_ctrl_model.cmd(WR, 3'h1, 16'h1010);
        repeat (20) @(negedge clk);
        wrStrobeFault = 1'b0;
        chk16("queue drained", 16'h0001, {15'h0000, wrDataReady});
        i_ddrbr_ctrl_model.cmd(RD, 3'h1, 16'h0010);
        grab();
        chk16("chop beats", 16'h0004, 16'(got.size()));
        for (int i = 0; i < 4; i++) chk16("read data", (16'h5a00 + 16'(i)) ^ {16{fault}}, got[i]);
        i_ddrbr_ctrl_model.cmd(PRE, 3'h1, 16'h0000);
    endtask
    // Refresh advances the internal row and leaves the banks idle.
    task automatic t_ref();
        logic [15:0] row;
        i_ddrbr_ctrl_model.cmd(ACT, 3'h3, 16'h0000);
        row = refreshRow;
        i_ddrbr_ctrl_model.refresh();
        chk16("refresh row", row + 16'h0001, refreshRow);
        chk16("banks idle", 16'h0000, {8'h00, bankOpen});
        chk16("refresh done", 16'h0000, {15'h0000, refreshBusy});
    endtask
    // Pull in more refreshes than may be credited, then pay back whatever is owed.
    task automatic t_credit();
        int c;
        repeat (`DDRBR_CREDIT_MAX + 2) i_ddrbr_ctrl_model.refresh();
        c = i_ddrbr_ctrl_model.credit;
        chk16("credit cap", 16'h0000, {15'h0000, c > `DDRBR_CREDIT_MAX});
        i_ddrbr_ctrl_model.drain();
        c = i_ddrbr_ctrl_model.credit;
        chk16("postponed left", 16'h0000, {15'h0000, c < 0});
        chk16("credit fault", 16'h0000, {15'h0000, i_ddrbr_ctrl_model.creditFault});
    endtask
    initial begin
        #100us;
        n_fail++;
        results();
    end
    initial begin
        srst = 1'b1;
        mrBurstMode = 2'h0;
        wrStrobeFault = 1'b0;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        chk16("reset banks", 16'h0000, {8'h00, bankOpen});
        chk16("reset busy", 16'h0000, {15'h0000, refreshBusy});
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 4; k++) t_size(2'(m), k[0], k[1]);
        end
        t_closed();
        t_data(1'b1);
        t_data(1'b0);
        t_ref();
        t_ref();
        t_credit();
        results();
    end
endmodule // tb_ddrbr_core
